// ---- sls_pkg.sv ----
// Shared constants, types and scrambler function for the serial link startup sequencer
package sls_pkg;

  // Clock and calibration timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS   = 2000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CNT_W     = 16;

  // Register map, byte addresses on the Avalon-MM slave
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_DECIM  = 4'h4;
  localparam logic [3:0] REG_KM1    = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // Control register fields
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_SCRAM   = 1;
  localparam int CTRL_CAL     = 2;
  localparam int CTRL_DDR     = 3;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CAL_BUSY  = 2;
  localparam int STAT_ALIGNED   = 3;

  // Configuration fields and reset values
  localparam int         DECIM_W      = 6;
  localparam logic [5:0] DECIM_RST    = 6'h04;
  localparam logic [5:0] DECIM_BYPASS = 6'h01;
  localparam int         KM1_W        = 5;
  localparam logic [4:0] KM1_RST      = 5'h1f;

  // Lane word: two octets per clock, one control flag per octet
  localparam int LANE_W = 16;
  localparam int K_W    = 2;
  localparam int RAW_W  = 12;

  // Control characters
  localparam logic [7:0] K_CGS       = 8'hbc;
  localparam logic [7:0] K_ILA_START = 8'h1c;
  localparam logic [7:0] K_ILA_END   = 8'h7c;
  localparam logic [7:0] K_ILA_CFG   = 8'h9c;

  // Sequence lengths
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  localparam logic [2:0] CGS_LOCK    = 3'h4;
  localparam int         FIFO_DEPTH  = 8;

  // Scrambler 1 + x^14 + x^15
  localparam int          SCR_W    = 15;
  localparam logic [14:0] SCR_SEED = 15'h7fff;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_CGS  = 2'b01,
    ST_ILA  = 2'b10,
    ST_DATA = 2'b11
  } sls_state_t;

  // Returns {next state, output word}; descr selects the receive direction
  function automatic logic [30:0] sls_scramble(input logic [15:0] din,
                                                input logic [14:0] sin,
                                                input logic        descr);
    logic [15:0] o;
    logic [14:0] s;
    o = 16'h0000;
    s = sin;
    for (int i = 15; i >= 0; i--) begin
      o[i] = din[i] ^ s[14] ^ s[13];
      s    = {s[13:0], (descr ? din[i] : o[i])};
    end
    return {s, o};
  endfunction

endpackage

// ---- sls_link_if.sv ----
// Serial lane, sync request and SYSREF between transmitter and receiver
interface sls_link_if;
  logic [15:0] lane_data;
  logic [1:0]  lane_k;
  logic        sync_n;
  logic        sysref;

  modport dev (output lane_data, output lane_k, input sync_n, input sysref);
  modport rcv (input lane_data, input lane_k, output sync_n, output sysref);
endinterface

// ---- sls_device.sv ----
// Transmit end: register slave, sample FIFO, startup sequencer and lane framer
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.

// Sample FIFO with registered flags
module sls_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic [PW:0]      count_nxt;
  logic             push;
  logic             pop;

  // Handshakes move data only when both sides agree
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
  assign out_data  = mem[rd_ptr_r];

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers advanced on handshakes, flags registered from the next count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_r  <= push ? PW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r;
      rd_ptr_r  <= pop ? PW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r;
      count_r   <= count_nxt;
      in_ready  <= count_nxt != (PW+1)'(DEPTH);
      out_valid <= count_nxt != '0;
    end
  end
endmodule // sls_fifo

module sls_device (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Avalon-MM register slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Sample stream in
  input  wire logic [15:0] SAMPLE_DATA,
  input  wire logic        SAMPLE_VALID,
  output logic             SAMPLE_READY,
  // Serial link
  sls_link_if.dev          LINK
);
  sls_pkg::sls_state_t state_r;
  sls_pkg::sls_state_t state_nxt;

  logic                            link_en_r;
  logic                            scram_r;
  logic                            ddr_r;
  logic [sls_pkg::DECIM_W-1:0]     decim_r;
  logic [sls_pkg::KM1_W-1:0]       km1_r;
  logic [sls_pkg::CAL_CNT_W-1:0]   cal_cnt_r;
  logic [sls_pkg::KM1_W-1:0]       lmfc_r;
  logic [1:0]                      ila_mf_r;
  logic                            sysref_d_r;
  logic                            aligned_r;
  logic                            sync_seen_r;
  logic [sls_pkg::SCR_W-1:0]       scr_r;
  logic [sls_pkg::LANE_W-1:0]      lane_data_r;
  logic [sls_pkg::K_W-1:0]         lane_k_r;
  logic [15:0]                     fifo_data;
  logic                            fifo_valid;

  // Bus decode: one wait cycle per access, write lands on the release edge
  logic        wr_en;
  logic        wr_ctrl;
  logic        cfg_ok;
  logic [31:0] rd_mux;
  assign wr_en   = AVS_WRITE & ~AVS_WAITREQUEST;
  assign wr_ctrl = wr_en & (AVS_ADDRESS == sls_pkg::REG_CTRL);
  assign cfg_ok  = ~link_en_r;
  assign rd_mux  =
    (AVS_ADDRESS == sls_pkg::REG_CTRL)   ? 32'({ddr_r, 1'b0, scram_r, link_en_r}) :
    (AVS_ADDRESS == sls_pkg::REG_DECIM)  ? 32'(decim_r) :
    (AVS_ADDRESS == sls_pkg::REG_KM1)    ? 32'(km1_r) :
    (AVS_ADDRESS == sls_pkg::REG_STATUS) ? 32'({aligned_r, (cal_cnt_r != '0), state_r}) :
    32'h0000_0000;

  // LMFC phase and multiframe boundary
  logic sysref_rise;
  logic mf_end;
  assign sysref_rise = LINK.sysref & ~sysref_d_r;
  assign mf_end      = lmfc_r == km1_r;

  // Drain only while sending data, so the FIFO fills during startup
  logic fifo_pop;
  logic bypass;
  assign fifo_pop = state_r == sls_pkg::ST_DATA;
  assign bypass   = decim_r == sls_pkg::DECIM_BYPASS;

  sls_fifo #(
    .WIDTH (16),
    .DEPTH (sls_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst       (RST),
    .in_data   (SAMPLE_DATA),
    .in_valid  (SAMPLE_VALID),
    .in_ready  (SAMPLE_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Startup sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sls_pkg::ST_OFF:  if (link_en_r) state_nxt = sls_pkg::ST_CGS;
      sls_pkg::ST_CGS:  if (sync_seen_r & LINK.sync_n & mf_end) begin
        state_nxt = sls_pkg::ST_ILA;
      end
      sls_pkg::ST_ILA:  if (mf_end & (ila_mf_r == sls_pkg::ILA_LAST_MF)) begin
        state_nxt = sls_pkg::ST_DATA;
      end
      sls_pkg::ST_DATA: state_nxt = sls_pkg::ST_DATA;
    endcase
    if ((state_r != sls_pkg::ST_OFF) & ~LINK.sync_n) state_nxt = sls_pkg::ST_CGS;
    if (~link_en_r) state_nxt = sls_pkg::ST_OFF;
  end

  // Lane word for the current state
  logic [sls_pkg::LANE_W-1:0] lane_nxt;
  logic [sls_pkg::K_W-1:0]    k_nxt;
  logic [30:0]                scr_out;
  logic [15:0]                payload;
  logic [7:0]                 ila_oct;
  assign payload = ~fifo_valid ? 16'h0000 :
                   bypass ? 16'(fifo_data[sls_pkg::RAW_W-1:0]) : fifo_data;
  assign scr_out = sls_pkg::sls_scramble(payload, scr_r, 1'b0);
  assign ila_oct = 8'({ila_mf_r, lmfc_r});

  always_comb begin
    lane_nxt = 16'h0000;
    k_nxt    = 2'h0;
    unique case (state_r)
      sls_pkg::ST_OFF: begin
        lane_nxt = 16'h0000;
      end
      sls_pkg::ST_CGS: begin
        lane_nxt = {sls_pkg::K_CGS, sls_pkg::K_CGS};
        k_nxt    = 2'h3;
      end
      sls_pkg::ST_ILA: begin
        lane_nxt = {ila_oct, ila_oct};
        if (lmfc_r == '0) begin
          lane_nxt[15:8] = sls_pkg::K_ILA_START;
          k_nxt[1]       = 1'b1;
        end
        if ((lmfc_r == '0) & (ila_mf_r == 2'h1)) begin
          lane_nxt[7:0] = sls_pkg::K_ILA_CFG;
          k_nxt[0]      = 1'b1;
        end else if (mf_end) begin
          lane_nxt[7:0] = sls_pkg::K_ILA_END;
          k_nxt[0]      = 1'b1;
        end
      end
      sls_pkg::ST_DATA: begin
        lane_nxt = scram_r ? scr_out[15:0] : payload;
      end
    endcase
  end

  // Register file and bus answer
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
      link_en_r       <= 1'b0;
      scram_r         <= 1'b0;
      ddr_r           <= 1'b0;
      decim_r         <= sls_pkg::DECIM_RST;
      km1_r           <= sls_pkg::KM1_RST;
      cal_cnt_r       <= '0;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST) AVS_READDATA <= rd_mux;
      if (wr_ctrl) link_en_r <= AVS_WRITEDATA[sls_pkg::CTRL_LINK_EN];
      if (wr_ctrl & cfg_ok) begin
        scram_r <= AVS_WRITEDATA[sls_pkg::CTRL_SCRAM];
        ddr_r   <= AVS_WRITEDATA[sls_pkg::CTRL_DDR];
      end
      if (wr_en & cfg_ok & (AVS_ADDRESS == sls_pkg::REG_DECIM)) begin
        decim_r <= AVS_WRITEDATA[sls_pkg::DECIM_W-1:0];
      end
      if (wr_en & cfg_ok & (AVS_ADDRESS == sls_pkg::REG_KM1)) begin
        km1_r <= AVS_WRITEDATA[sls_pkg::KM1_W-1:0];
      end
      // Trigger bit is a pulse; it never reads back as set
      if (wr_ctrl & AVS_WRITEDATA[sls_pkg::CTRL_CAL]) begin
        cal_cnt_r <= sls_pkg::CAL_CNT_W'(sls_pkg::CAL_CYCLES);
      end else if (cal_cnt_r != '0) begin
        cal_cnt_r <= cal_cnt_r - 1'b1;
      end
    end
  end

  // LMFC, sequencer and lane registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r     <= sls_pkg::ST_OFF;
      lmfc_r      <= '0;
      ila_mf_r    <= 2'h0;
      sysref_d_r  <= 1'b0;
      aligned_r   <= 1'b0;
      sync_seen_r <= 1'b0;
      scr_r       <= sls_pkg::SCR_SEED;
      lane_data_r <= 16'h0000;
      lane_k_r    <= 2'h0;
    end else begin
      state_r     <= state_nxt;
      sysref_d_r  <= LINK.sysref;
      lmfc_r      <= (sysref_rise | mf_end) ? '0 : lmfc_r + 1'b1;
      // Clear from a disabled link wins over the set
      aligned_r   <= (sysref_rise & link_en_r) | (aligned_r & link_en_r);
      sync_seen_r <= (state_r == sls_pkg::ST_CGS) & (sync_seen_r | ~LINK.sync_n);
      if (state_r != sls_pkg::ST_ILA) ila_mf_r <= 2'h0;
      else if (mf_end) ila_mf_r <= ila_mf_r + 1'b1;
      scr_r       <= (fifo_pop & scram_r) ? scr_out[30:16] : sls_pkg::SCR_SEED;
      lane_data_r <= lane_nxt;
      lane_k_r    <= k_nxt;
    end
  end

  // Link outputs straight from flops
  assign LINK.lane_data = lane_data_r;
  assign LINK.lane_k    = lane_k_r;
endmodule // sls_device

// ---- sls_receiver.sv ----
// Receive end: sync request, SYSREF source, ILA tracking and sample output
module sls_receiver (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // User control
  input  wire logic        START,
  input  wire logic        SYSREF_REQ,
  input  wire logic        SCRAMBLE,
  // User data out
  output logic      [15:0] RX_DATA,
  output logic             RX_VALID,
  output logic             RX_SYNCED,
  // Serial link
  sls_link_if.rcv          LINK
);
  sls_pkg::sls_state_t state_r;
  sls_pkg::sls_state_t state_nxt;

  logic [2:0]                cgs_cnt_r;
  logic [1:0]                a_cnt_r;
  logic [sls_pkg::SCR_W-1:0] scr_r;
  logic                      sync_n_r;
  logic                      sysref_r;

  // Character classification
  logic        is_cgs;
  logic        is_end;
  logic        is_data;
  logic [30:0] dscr;
  assign is_cgs  = (LINK.lane_k == 2'h3) &
                   (LINK.lane_data == {sls_pkg::K_CGS, sls_pkg::K_CGS});
  assign is_end  = LINK.lane_k[0] & (LINK.lane_data[7:0] == sls_pkg::K_ILA_END);
  assign is_data = (state_r == sls_pkg::ST_DATA) & (LINK.lane_k == 2'h0);
  assign dscr    = sls_pkg::sls_scramble(LINK.lane_data, scr_r, 1'b1);

  // Lock after a run of sync characters, data after the last ILA end mark
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sls_pkg::ST_OFF:  if (START) state_nxt = sls_pkg::ST_CGS;
      sls_pkg::ST_CGS:  if (is_cgs & (cgs_cnt_r == sls_pkg::CGS_LOCK - 3'h1)) begin
        state_nxt = sls_pkg::ST_ILA;
      end
      sls_pkg::ST_ILA:  if (is_end & (a_cnt_r == sls_pkg::ILA_LAST_MF)) begin
        state_nxt = sls_pkg::ST_DATA;
      end
      sls_pkg::ST_DATA: state_nxt = sls_pkg::ST_DATA;
    endcase
    if (~START) state_nxt = sls_pkg::ST_OFF;
  end

  // Sequencer, sync request and outputs
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r   <= sls_pkg::ST_OFF;
      cgs_cnt_r <= 3'h0;
      a_cnt_r   <= 2'h0;
      scr_r     <= sls_pkg::SCR_SEED;
      sync_n_r  <= 1'b1;
      sysref_r  <= 1'b0;
      RX_DATA   <= 16'h0000;
      RX_VALID  <= 1'b0;
      RX_SYNCED <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cgs_cnt_r <= (is_cgs & (state_r == sls_pkg::ST_CGS)) ? cgs_cnt_r + 3'h1 : 3'h0;
      if (state_r != sls_pkg::ST_ILA) a_cnt_r <= 2'h0;
      else if (is_end) a_cnt_r <= a_cnt_r + 2'h1;
      sync_n_r  <= state_nxt != sls_pkg::ST_CGS;
      sysref_r  <= SYSREF_REQ;
      // Self-synchronising descrambler restarts with each data phase
      scr_r     <= (is_data & SCRAMBLE) ? dscr[30:16] : sls_pkg::SCR_SEED;
      RX_VALID  <= is_data;
      if (is_data) RX_DATA <= SCRAMBLE ? dscr[15:0] : LINK.lane_data;
      RX_SYNCED <= state_nxt == sls_pkg::ST_DATA;
    end
  end

  assign LINK.sync_n = sync_n_r;
  assign LINK.sysref = sysref_r;
endmodule // sls_receiver

// ---- sls_properties.sv ----
// Checker: sync, ILA framing and data-start properties on the link signals
module sls_properties (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Link signals
  input  wire logic [15:0] lane_data,
  input  wire logic [1:0]  lane_k,
  input  wire logic        sync_n,
  input  wire logic        sysref
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lane word classes
  wire is_cgs   = lane_k == 2'b11 && lane_data == {sls_pkg::K_CGS, sls_pkg::K_CGS};
  wire is_start = lane_k[1] && lane_data[15:8] == sls_pkg::K_ILA_START;
  wire is_end   = lane_k == 2'b01 && lane_data[7:0] == sls_pkg::K_ILA_END;
  // Config mark shares its word with a start mark, so only the low flag matters
  wire is_cfg   = lane_k[0] && lane_data[7:0] == sls_pkg::K_ILA_CFG;

  // ILA bookkeeping; multiframe length is learnt from the first end mark
  logic [7:0] since_r, klen_r, gap_r;
  logic [1:0] ends_r;
  logic       data_r;
  logic       cgs_d_r;
  // Every multiframe opens with a start mark; only the one after sync characters restarts counts
  wire        ila_go    = is_start && cgs_d_r;
  wire  [7:0] since_nxt = ila_go ? 8'h01 : since_r + 8'h01;
  wire  [7:0] klen_nxt  = (is_end && ends_r == 2'h0) ? since_r + 8'h01 : klen_r;
  wire  [7:0] gap_nxt   = is_end ? 8'h01 : gap_r + 8'h01;
  wire  [1:0] ends_nxt  = ila_go ? 2'h0 : ends_r + {1'b0, is_end};
  wire        data_nxt  = sync_n && (data_r || (is_end && ends_r == 2'h3));

  // Counters wrap harmlessly: they are only looked at on marker words
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {since_r, klen_r, gap_r, ends_r, data_r, cgs_d_r} <= '0;
    end else begin
      {since_r, klen_r, gap_r, ends_r, data_r, cgs_d_r} <= {since_nxt, klen_nxt, gap_nxt,
                                                            ends_nxt, data_nxt, is_cgs};
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // Link properties
  chk_cgs_repeat: assert property ((!sync_n) [*4] |-> is_cgs)
    else $error("sync request held but lane not sending sync characters");
  chk_ila_after_sync: assert property ($rose(sync_n) && is_cgs |-> ##[1:80] is_start)
    else $error("no ILA start after sync release");
  chk_sync_lock: assert property ($rose(sync_n) |-> $past(is_cgs, 1) && $past(is_cgs, 2)
    && $past(is_cgs, 3) && $past(is_cgs, 4))
    else $error("sync released before four sync words");
  chk_ila_preceded: assert property (is_start |-> $past(is_cgs) || $past(is_end))
    else $error("ILA start not preceded by sync characters or an end mark");
  chk_cfg_place: assert property (is_cfg |-> since_r == klen_r)
    else $error("config marker not at start of second multiframe");
  chk_mark_gap: assert property (is_end && ends_r != 2'h0 |-> gap_r == klen_r)
    else $error("end marks not one multiframe apart");
  chk_data_follow: assert property (is_end && ends_r == 2'h3 |=> lane_k == 2'b00)
    else $error("gap or control word after last ILA frame");
  chk_data_plain: assert property (data_r && sync_n |-> lane_k == 2'b00)
    else $error("control word inside data phase");

  cov_sysref: cover property ($rose(sysref));
endmodule // sls_properties

// ---- tb.sv ----
// Testbench: both link ends, register and sample tasks, self-checks
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observed signals
  logic        clock, rst, av_rd, av_wr, s_valid, start, sys_req, scram;
  logic        av_wait, s_ready, rx_valid, rx_synced;
  logic [3:0]  av_addr;
  logic [31:0] av_wd, av_q, rd;
  logic [15:0] s_data, rx_data;
  logic [15:0] exp_q[$];
  int          failures, cmp_count;

  sls_link_if link ();
  sls_device sls_device_i (.CLOCK(clock), .RST(rst), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
    .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_q), .AVS_WAITREQUEST(av_wait),
    .SAMPLE_DATA(s_data), .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready), .LINK(link.dev));
  sls_receiver sls_receiver_i (.CLOCK(clock), .RST(rst), .START(start), .SYSREF_REQ(sys_req),
    .SCRAMBLE(scram), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_SYNCED(rx_synced),
    .LINK(link.rcv));
  sls_properties sls_properties_i (.CLOCK(clock), .RST(rst), .lane_data(link.lane_data),
    .lane_k(link.lane_k), .sync_n(link.sync_n), .sysref(link.sysref));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  // A hung slave is left to the run-length guard
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    av_addr <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    do begin
      @(posedge clock);
    end while (av_wait !== 1'b0);
    rd = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  // Push one sample, held until the FIFO takes it or 50 cycles pass
  task automatic push(input logic [15:0] d);
    int n;
    n = 0;
    s_data <= d;
    s_valid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (s_ready !== 1'b1 && n < 50);
    s_valid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_sync(input logic v);
    for (int n = 0; n < 2000 && rx_synced !== v; n++) @(posedge clock);
    check(32'(rx_synced), 32'(v));
  endtask

  // Bypass sends only the raw 12 bits
  function automatic logic [15:0] expect_word(input logic [15:0] s, input logic [5:0] dec);
    return (dec == sls_pkg::DECIM_BYPASS) ? {4'h0, s[11:0]} : s;
  endfunction

  // Received words against buffered samples, in order
  always @(posedge clock) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0) check(32'(rx_data), 32'(exp_q.pop_front()));
  end

  // Run-length guard
  initial begin
    #500000;
    failures++;
    close_out();
  end

  // Main sequence: corner settings first, then random ones
  initial begin
    logic [4:0]  km1;
    logic [5:0]  dec;
    logic [15:0] w;
    logic        sr, ddr;
    failures = 0;
    cmp_count = 0;
    {rst, av_rd, av_wr, s_valid, start, sys_req, scram} = 7'h40;
    av_addr = 4'h0;
    av_wd = 32'h0;
    s_data = 16'h0;
    void'($urandom(54));
    for (int t = 0; t < 5; t++) begin
      km1 = (t == 0) ? 5'h01 : (t == 1) ? 5'h1f : 5'($urandom_range(1, 31));
      dec = (t == 0) ? sls_pkg::DECIM_BYPASS : 6'($urandom_range(1, 8));
      sr = (t != 1);
      ddr = 1'($urandom);
      rst <= 1'b1;
      start <= 1'b0;
      scram <= 1'($urandom);
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd_chk(sls_pkg::REG_DECIM, 32'(sls_pkg::DECIM_RST));
      rd_chk(sls_pkg::REG_KM1, 32'(sls_pkg::KM1_RST));
      rd_chk(sls_pkg::REG_STATUS, 32'h0);
      bus(sls_pkg::REG_CTRL, 1'b1, 32'h0);
      bus(sls_pkg::REG_DECIM, 1'b1, 32'(dec));
      bus(sls_pkg::REG_KM1, 1'b1, 32'(km1));
      bus(sls_pkg::REG_CTRL, 1'b1, {28'h0, ddr, 1'b1, scram, 1'b0});
      bus(4'h2, 1'b1, 32'hffffffff);
      bus(sls_pkg::REG_STATUS, 1'b1, 32'h0000000b);
      rd_chk(4'h2, 32'h0);
      rd_chk(sls_pkg::REG_STATUS, 32'h00000004);
      rd_chk(sls_pkg::REG_CTRL, {28'h0, ddr, 1'b0, scram, 1'b0});
      rd_chk(sls_pkg::REG_DECIM, 32'(dec));
      rd_chk(sls_pkg::REG_KM1, 32'(km1));
      // Fill the FIFO while the link is off, until it refuses
      for (int i = 0; i < 8; i++) begin
        w = (i == 0) ? 16'hffff : 16'($urandom);
        exp_q.push_back(expect_word(w, dec));
        push(w);
      end
      repeat (2) @(posedge clock);
      check(32'(s_ready), 32'h0);
      bus(sls_pkg::REG_CTRL, 1'b1, {28'h0, ddr, 1'b0, scram, 1'b1});
      // Settings stay locked while the link runs
      bus(sls_pkg::REG_CTRL, 1'b1, {28'h0, !ddr, 1'b0, !scram, 1'b1});
      bus(sls_pkg::REG_KM1, 1'b1, 32'(~km1));
      rd_chk(sls_pkg::REG_CTRL, {28'h0, ddr, 1'b0, scram, 1'b1});
      rd_chk(sls_pkg::REG_KM1, 32'(km1));
      sys_req <= sr;
      @(posedge clock);
      sys_req <= 1'b0;
      start <= 1'b1;
      wait_sync(1'b1);
      bus(sls_pkg::REG_STATUS, 1'b0, 32'h0);
      check(32'({rd[3], rd[1:0]}), 32'({sr, 2'h3}));
      for (int n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge clock);
      check(32'(exp_q.size()), 32'h0);
      // Renewed sync request in mid-data sends the link back to sync
      start <= 1'b0;
      repeat (3) @(posedge clock);
      start <= 1'b1;
      wait_sync(1'b0);
      wait_sync(1'b1);
      $display("test %0d done", t);
    end
    close_out();
  end
endmodule // tb
